/* File: hw/pwmtoc_pkg.sv */
// Package for the two-channel pwm timer output stage.
// Assumes a 32-bit AHB-Lite register bus and a single 40 MHz clock.
package pwmtoc_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam logic [11:0] OFS_MODE = 12'h000;
   localparam logic [11:0] OFS_POL = 12'h004;
   localparam logic [11:0] OFS_VAL = 12'h008;
   localparam logic [11:0] OFS_OE = 12'h00C;
   localparam logic [11:0] OFS_DIR = 12'h010;
   localparam logic [11:0] OFS_PER = 12'h014;
   localparam logic [11:0] OFS_DUTY = 12'h018;
   localparam logic [11:0] OFS_CTRL = 12'h01C;
   localparam logic [11:0] OFS_STAT = 12'h020;
   localparam int CH0 = 0;
   localparam int CH1 = 1;
   localparam int DIR_BIT = 6;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_SLV_TRIG = 1;
   localparam logic [15:0] RST_16 = 16'h0000;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [15:0] RST_PER = 16'h0000;
   localparam logic [15:0] RST_DUTY = 16'h0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic [2:0] {
      PWMTOC_S_IDLE = 3'h1,
      PWMTOC_S_RUN = 3'h2,
      PWMTOC_S_HOLD = 3'h4
   } pwmtoc_run_t;
endpackage

/* File: hw/pwmtoc_cnt_if.sv */
// Interface carrying counter events between the core and the counter pair.
// Assumes both ends share the one system clock.
`timescale 1ns/1ps
`default_nettype none
interface pwmtoc_cnt_if;
   logic run;
   logic slave_trig_en;
   logic [15:0] period;
   logic [15:0] duty;
   logic master_irq;
   logic slave_irq;
   modport core (output run, output slave_trig_en, output period,
      output duty, input master_irq, input slave_irq);
   modport cnt (input run, input slave_trig_en, input period,
      input duty, output master_irq, output slave_irq);
endinterface
`default_nettype wire

/* File: hw/pwmtoc_counter.sv */
// Master interval counter and slave one-count counter.
// Assumes period and duty are stable while run is high.
`timescale 1ns/1ps
`default_nettype none
module pwmtoc_counter
   import pwmtoc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Core side
   pwmtoc_cnt_if.cnt cnt
);
   typedef struct packed {
      logic [15:0] mcnt;
      logic [15:0] scnt;
      logic sact;
      logic mirq;
      logic sirq;
      logic run_d;
   } pwmtoc_cnt_st_t;
   pwmtoc_cnt_st_t st_ff, nxt_st;

   assign cnt.master_irq = st_ff.mirq;
   assign cnt.slave_irq = st_ff.sirq;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.mirq = 1'b0;
      nxt_st.sirq = 1'b0;
      nxt_st.run_d = cnt.run;
      if (!cnt.run) begin
         nxt_st.mcnt = 16'h0000;
         nxt_st.sact = 1'b0;
      end else begin
         // Master reloads every period+1 counts
         if (!st_ff.run_d || st_ff.mcnt == 16'h0000) begin
            nxt_st.mcnt = cnt.period;
            nxt_st.mirq = 1'b1;
         end else begin
            nxt_st.mcnt = st_ff.mcnt - 16'h0001;
         end
         // Slave counts duty cycles after the master event
         // Slave end lands duty clocks after the master event, or one clock after it when duty is 0
         if (st_ff.mirq && cnt.slave_trig_en) begin
            nxt_st.scnt = cnt.duty - 16'h0001;
            nxt_st.sact = 1'b1;
            if (cnt.duty <= 16'h0001) begin
               nxt_st.sirq = 1'b1;
               nxt_st.sact = 1'b0;
            end
         end else if (st_ff.sact) begin
            if (st_ff.scnt == 16'h0001) begin
               nxt_st.sirq = 1'b1;
               nxt_st.sact = 1'b0;
            end
            nxt_st.scnt = st_ff.scnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule
`default_nettype wire

/* File: hw/pwmtoc_top.sv */
// Output stage of a two-channel pwm timer with AHB-Lite register access.
// Assumes one AHB-Lite master, synchronous inputs, a 40 MHz clock.
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pwmtoc_top
   import pwmtoc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Pulse pins
   output logic chan0_pin_out,
   output logic chan1_pin_out,
   output logic chan1_pin_oe_n_out
);
   import pwmtoc_pkg::*;

   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] pol;
      logic [15:0] val;
      logic [15:0] oe;
      logic [7:0] dir;
      logic [15:0] per;
      logic [15:0] duty;
      logic [1:0] ctrl;
      pwmtoc_run_t run_st;
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
      logic [15:0] since;
      logic pin0;
      logic pin1;
      logic pin1_oe_n;
   } pwmtoc_st_t;
   pwmtoc_st_t st_ff, nxt_st;

   pwmtoc_cnt_if cif();

   pwmtoc_counter u_counter (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .cnt(cif.cnt)
   );

   assign cif.run = (st_ff.run_st == PWMTOC_S_RUN);
   assign cif.slave_trig_en = st_ff.ctrl[CTRL_SLV_TRIG];
   assign cif.period = st_ff.per;
   assign cif.duty = st_ff.duty;

   function automatic logic [31:0] rd_mux(input pwmtoc_st_t s,
                                          input logic [11:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         OFS_MODE: r = {16'h0000, s.mode};
         OFS_POL: r = {16'h0000, s.pol};
         OFS_VAL: r = {16'h0000, s.val};
         OFS_OE: r = {16'h0000, s.oe};
         OFS_DIR: r = {24'h000000, s.dir};
         OFS_PER: r = {16'h0000, s.per};
         OFS_DUTY: r = {16'h0000, s.duty};
         OFS_CTRL: r = {30'h0000_0000, s.ctrl};
         OFS_STAT: r = {29'h0000_0000, s.run_st};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // Next output level from the timer events for one channel
   function automatic logic ch_next(input logic cur, input logic md,
                                    input logic own_irq, input logic mi,
                                    input logic si);
      logic n;
      n = cur;
      if (!md) begin
         if (own_irq) begin
            n = ~cur;
         end
      end else begin
         if (mi) begin
            n = 1'b1;
         end else if (si) begin
            n = 1'b0;
         end
      end
      return n;
   endfunction

   logic take;
   assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

   always_comb begin
      logic [15:0] wv;
      wv = hwdata[15:0];
      nxt_st = st_ff;
      // Address phase capture; read data ready at the data phase edge
      nxt_st.wr_pend = 1'b0;
      if (take) begin
         nxt_st.wr_pend = hwrite;
         nxt_st.wr_addr = haddr[11:0];
         nxt_st.rdata = rd_mux(st_ff, haddr[11:0]);
      end
      // Clocks since the last master event, watched by the checks below
      nxt_st.since = cif.master_irq ? 16'h0001 : st_ff.since + 16'h0001;
      // Timer drives the value bits while enabled
      if (st_ff.oe[CH1]) begin
         nxt_st.val[CH1] = ch_next(st_ff.val[CH1], st_ff.mode[CH1],
            cif.slave_irq, cif.master_irq, cif.slave_irq);
      end
      if (st_ff.oe[CH0]) begin
         nxt_st.val[CH0] = ch_next(st_ff.val[CH0], 1'b0,
            cif.master_irq, 1'b0, 1'b0);
      end
      if (st_ff.wr_pend) begin
         case (st_ff.wr_addr)
            OFS_MODE: nxt_st.mode = {14'h0000, wv[1], 1'b0};
            OFS_POL: nxt_st.pol = {14'h0000, wv[1], 1'b0};
            OFS_VAL: begin
               // Writes only land on channels not under timer control
               if (!st_ff.oe[CH1]) begin
                  nxt_st.val[CH1] = wv[CH1];
               end
               if (!st_ff.oe[CH0]) begin
                  nxt_st.val[CH0] = wv[CH0];
               end
            end
            OFS_OE: nxt_st.oe = {14'h0000, wv[1:0]};
            OFS_DIR: nxt_st.dir = hwdata[7:0];
            OFS_PER: nxt_st.per = wv;
            OFS_DUTY: nxt_st.duty = wv;
            OFS_CTRL: nxt_st.ctrl = hwdata[1:0];
            default: ;
         endcase
      end
      case (st_ff.run_st)
         PWMTOC_S_IDLE: begin
            if (st_ff.ctrl[CTRL_RUN]) begin
               nxt_st.run_st = PWMTOC_S_RUN;
            end
         end
         PWMTOC_S_RUN: begin
            if (!st_ff.ctrl[CTRL_RUN]) begin
               nxt_st.run_st = PWMTOC_S_HOLD;
            end
         end
         PWMTOC_S_HOLD: nxt_st.run_st = PWMTOC_S_IDLE;
         default: nxt_st.run_st = PWMTOC_S_IDLE;
      endcase
      // Pin stage uses the updated value bits
      nxt_st.pin0 = nxt_st.val[CH0];
      nxt_st.pin1 = nxt_st.val[CH1] ^ nxt_st.pol[CH1];
      nxt_st.pin1_oe_n = nxt_st.dir[DIR_BIT];
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         st_ff <= '0;
         st_ff.dir <= RST_DIR;
         st_ff.run_st <= PWMTOC_S_IDLE;
         st_ff.pin1_oe_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign hrdata = st_ff.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign chan0_pin_out = st_ff.pin0;
   assign chan1_pin_out = st_ff.pin1;
   assign chan1_pin_oe_n_out = st_ff.pin1_oe_n;

   // Software access to the value bits and to the read data

   property p_wr_ignored;
      @(posedge sys_clk_in) disable iff (reset_in)
         st_ff.wr_pend && st_ff.wr_addr == OFS_VAL && st_ff.oe[CH1] &&
         !cif.master_irq && !cif.slave_irq
         |=> $stable(st_ff.val[CH1]);
   endproperty
   a_wr_ignored: assert property (p_wr_ignored)
      else $error("value write landed while enabled");

   property p_wr_taken;
      @(posedge sys_clk_in) disable iff (reset_in)
         st_ff.wr_pend && st_ff.wr_addr == OFS_VAL && !st_ff.oe[CH1]
         |=> st_ff.val[CH1] == $past(hwdata[1]);
   endproperty
   a_wr_taken: assert property (p_wr_taken)
      else $error("value write lost while disabled");

   property p_lock0;
      @(posedge sys_clk_in) disable iff (reset_in)
         st_ff.wr_pend && st_ff.wr_addr == OFS_VAL && st_ff.oe[CH0] &&
         !cif.master_irq
         |=> $stable(st_ff.val[CH0]);
   endproperty
   a_lock0: assert property (p_lock0)
      else $error("channel zero write landed while enabled");

   property p_sw0;
      @(posedge sys_clk_in) disable iff (reset_in)
         st_ff.wr_pend && st_ff.wr_addr == OFS_VAL && !st_ff.oe[CH0]
         |=> st_ff.val[CH0] == $past(hwdata[0]);
   endproperty
   a_sw0: assert property (p_sw0)
      else $error("channel zero write lost while disabled");

   property p_rdata;
      @(posedge sys_clk_in) disable iff (reset_in)
         !take |=> $stable(hrdata);
   endproperty
   a_rdata: assert property (p_rdata)
      else $error("read data moved without a transfer");

   // Pin stage

   property p_pol;
      @(posedge sys_clk_in) disable iff (reset_in)
         chan1_pin_out == (st_ff.val[CH1] ^ st_ff.pol[CH1]);
   endproperty
   a_pol: assert property (p_pol)
      else $error("pin polarity wrong");

   property p_dir;
      @(posedge sys_clk_in) disable iff (reset_in)
         chan1_pin_oe_n_out == st_ff.dir[DIR_BIT];
   endproperty
   a_dir: assert property (p_dir)
      else $error("pin direction wrong");

   // Timer driven output levels

   property p_set;
      @(posedge sys_clk_in) disable iff (reset_in)
         st_ff.oe[CH1] && st_ff.mode[CH1] && cif.master_irq &&
         !(st_ff.wr_pend && st_ff.wr_addr == OFS_MODE)
         |=> st_ff.val[CH1];
   endproperty
   a_set: assert property (p_set)
      else $error("master event did not set");

   property p_clr;
      @(posedge sys_clk_in) disable iff (reset_in)
         st_ff.oe[CH1] && st_ff.mode[CH1] && cif.slave_irq &&
         !cif.master_irq && !(st_ff.wr_pend && st_ff.wr_addr == OFS_MODE)
         |=> !st_ff.val[CH1];
   endproperty
   a_clr: assert property (p_clr)
      else $error("slave event did not clear");

   property p_tog1;
      @(posedge sys_clk_in) disable iff (reset_in)
         st_ff.oe[CH1] && !st_ff.mode[CH1] && cif.slave_irq &&
         !(st_ff.wr_pend && st_ff.wr_addr == OFS_MODE)
         |=> st_ff.val[CH1] != $past(st_ff.val[CH1]);
   endproperty
   a_tog1: assert property (p_tog1)
      else $error("channel one did not toggle");

   property p_tog;
      @(posedge sys_clk_in) disable iff (reset_in)
         st_ff.oe[CH0] && cif.master_irq
         |=> st_ff.val[CH0] != $past(st_ff.val[CH0]);
   endproperty
   a_tog: assert property (p_tog)
      else $error("channel zero did not toggle");

   // Counter timing, measured from the last master event, and no counter events while stopped

   property p_slv;
      @(posedge sys_clk_in) disable iff (reset_in)
         cif.slave_irq && cif.slave_trig_en && cif.duty != 16'h0000
         |-> st_ff.since == cif.duty;
   endproperty
   a_slv: assert property (p_slv)
      else $error("slave end not duty clocks after master");

   property p_per;
      @(posedge sys_clk_in) disable iff (reset_in)
         cif.master_irq && $past(cif.run) && $past(cif.run, 2)
         |-> {1'b0, st_ff.since} == {1'b0, cif.period} + 17'h00001;
   endproperty
   a_per: assert property (p_per)
      else $error("period not period plus one");

   property p_quiet;
      @(posedge sys_clk_in) disable iff (reset_in)
         !cif.run |=> !cif.master_irq && !cif.slave_irq;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("timer event while stopped");

   c_pwm: cover property (@(posedge sys_clk_in)
      cif.master_irq ##[1:50] cif.slave_irq);
   c_wr: cover property (@(posedge sys_clk_in)
      st_ff.wr_pend && st_ff.wr_addr == OFS_VAL);
   c_tog: cover property (@(posedge sys_clk_in)
      st_ff.oe[CH1] && !st_ff.mode[CH1] && cif.slave_irq);
   c_inv: cover property (@(posedge sys_clk_in)
      st_ff.oe[CH1] && st_ff.pol[CH1] && cif.slave_irq);
endmodule
`default_nettype wire

/* File: verification/pwmtoc_led_load.sv */
// Load on a pulse pin: measures high time and period of the pin level.
// Assumes the pin is pulled low while its driver is switched off.
`timescale 1ns/1ps
`default_nettype none
module pwmtoc_led_load (
   // Clock
   input wire logic clk_in,
   // Pin side
   input wire logic pin_in,
   input wire logic oe_n_in,
   // Pin level, and measurements in clock cycles
   output logic level_out,
   output int hi_out,
   output int per_out
);
   int hi_ff;
   int cnt_ff;
   logic last_ff;
   // Released pin falls to the pull-down level
   assign level_out = oe_n_in ? 1'b0 : pin_in;
   always_ff @(posedge clk_in) begin
      last_ff <= level_out;
      if (level_out && !last_ff) begin
         per_out <= cnt_ff;
         hi_out <= hi_ff;
         cnt_ff <= 1;
         hi_ff <= 1;
      end else begin
         cnt_ff <= cnt_ff + 1;
         hi_ff <= hi_ff + (level_out ? 1 : 0);
      end
   end
endmodule
`default_nettype wire

/* File: verification/test_pwm_timer_output_control.sv */
// Testbench for the pwm timer output stage over AHB-Lite.
// Assumes a zero-wait slave and a pull-down on the pulse pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
   error_cnt++; $display("BAD %s exp %h got %h", n, e, s); end end
module test_pwm_timer_output_control;
   import pwmtoc_pkg::*;
   localparam int P = 9;
   localparam int D = 3;
   logic sys_clk_in, reset_in, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, ch0, ch1, oe_n, lv0, lv1;
   int hi0, per0, hi1, per1, error_cnt, compares;
   int emode[3] = '{1, 1, 0};
   int epol[3] = '{0, 1, 0};
   int eper[3] = '{P + 1, P + 1, 2 * (P + 1)};
   int ehi[3] = '{D, P + 1 - D, P + 1};
   pwmtoc_top DUT (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .chan0_pin_out(ch0), .chan1_pin_out(ch1),
      .chan1_pin_oe_n_out(oe_n));
   pwmtoc_led_load u_load1 (.clk_in(sys_clk_in), .pin_in(ch1),
      .oe_n_in(oe_n), .level_out(lv1), .hi_out(hi1), .per_out(per1));
   pwmtoc_led_load u_load0 (.clk_in(sys_clk_in), .pin_in(ch0),
      .oe_n_in(1'b0), .level_out(lv0), .hi_out(hi0), .per_out(per0));
   initial begin
      sys_clk_in = 1'b0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end
   // One single word transfer; called just after a rising edge
   task automatic bus(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {20'h00000, a};
      hwrite <= w;
      do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      bus(1'b0, a, 32'h00000000);
   endtask
   task automatic test_done;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #(25ns * 20000);
      error_cnt++;
      test_done();
   end
   initial begin
      reset_in = 1'b1;
      {hsel, hwrite} = 2'h0;
      {haddr, hwdata} = 64'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      repeat (10) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      @(posedge sys_clk_in);
      `CHK("oe_n reset", 1'b1, oe_n)
      rd(OFS_MODE); `CHK("mode rst", {16'h0, RST_16}, r)
      rd(OFS_VAL); `CHK("val rst", {16'h0, RST_16}, r)
      rd(OFS_DIR); `CHK("dir rst", {24'h0, RST_DIR}, r)
      `CHK("hresp", 1'b0, hresp)
      rd(12'h040); `CHK("unmapped", 32'h00000000, r)
      wr(OFS_DIR, 32'h000000BF);
      @(posedge sys_clk_in);
      `CHK("oe_n on", 1'b0, oe_n)
      for (int v = 1; v <= 2; v++) begin
         wr(OFS_VAL, 32'(v));
         repeat (2) @(posedge sys_clk_in);
         `CHK("ch0 sw", v[0], ch0)
         `CHK("ch1 sw", v[1], lv1)
         rd(OFS_VAL); `CHK("val rd", 32'(v), r)
      end
      wr(OFS_PER, P);
      wr(OFS_DUTY, D);
      rd(OFS_PER); `CHK("per rd", 32'(P), r)
      wr(OFS_OE, 32'h00000003);
      wr(OFS_CTRL, 32'h00000003);
      for (int i = 0; i < 3; i++) begin
         wr(OFS_MODE, 32'(emode[i] << 1));
         wr(OFS_POL, 32'(epol[i] << 1));
         repeat (8 * (P + 1)) @(posedge sys_clk_in);
         `CHK("ch1 per", eper[i], per1)
         `CHK("ch1 hi", ehi[i], hi1)
         `CHK("ch0 per", 2 * (P + 1), per0)
         `CHK("ch0 hi", P + 1, hi0)
         rd(OFS_STAT); `CHK("stat run", 32'h00000002, r)
      end
      wr(OFS_CTRL, 32'h00000000);
      repeat (3) @(posedge sys_clk_in);
      rd(OFS_STAT); `CHK("stat idle", 32'h00000001, r)
      rd(OFS_VAL); `CHK("val follows", ch1, r[1])
      `CHK("val ch0", ch0, r[0])
      wr(OFS_VAL, {30'h0, ~r[1:0]});
      rd(OFS_VAL); `CHK("val locked", {30'h0, ch1, ch0}, r)
      repeat (2) @(posedge sys_clk_in);
      wr(OFS_DIR, 32'h000000FF);
      @(posedge sys_clk_in);
      `CHK("oe_n off", 1'b1, oe_n)
      `CHK("released", 1'b0, lv1)
      test_done();
   end
endmodule
`default_nettype wire
